/* l3r_cfg.svh */
// constants for the third low-dropout regulator register block
// assumes an APB slave with 32-bit data and word-indexed registers
`ifndef L3R_CFG_SVH
`define L3R_CFG_SVH
// register indices; byte address is four times the index
`define L3R_IDX_CTRL 10'h0CE
`define L3R_IDX_SEQ 10'h0CF
`define L3R_IDX_LP 10'h0D0
`define L3R_IDX_STS 10'h0D8
`define L3R_IDX_MASK 10'h0D9
`define L3R_IDX_HIB 10'h0DA
// writable bits of the control, sequencing and low-power registers, the rest read as zero
`define L3R_WMASK_CTRL 16'h441F
`define L3R_WMASK_SEQ 16'hFFC0
`define L3R_WMASK_LP 16'h331F
// mask-option defaults
`define L3R_DEF_CTRL 16'h001B
`define L3R_DEF_SEQ 16'h0400
`define L3R_DEF_LP 16'h001C
// field positions
`define L3R_SWITCH_BIT 14
`define L3R_FLOAT_BIT 10
`define L3R_FAULT_ACT_HI 15
`define L3R_FAULT_ACT_LO 14
`define L3R_START_HI 13
`define L3R_START_LO 10
`define L3R_STOP_HI 9
`define L3R_STOP_LO 6
`define L3R_HIB_BEH_HI 13
`define L3R_HIB_BEH_LO 12
`define L3R_HIB_SRC_HI 9
`define L3R_HIB_SRC_LO 8
`define L3R_CODE_HI 4
// interrupt status bits
`define L3R_IRQ_FAULT 0
`define L3R_IRQ_HIB 1
`define L3R_IRQ_BITS 2
// voltage scale in millivolts
`define L3R_HIGH_BASE_MV 12'h708
`define L3R_HIGH_STEP_MV 12'h064
`define L3R_LOW_BASE_MV 12'h384
`define L3R_LOW_STEP_MV 12'h032
// slot codes
`define L3R_SLOT_NONE 4'h0
`define L3R_SLOT_EDGE 4'hF
`endif

/* l3r_pkg.sv */
// types for the third low-dropout regulator register block
// assumes nothing beyond the constants header
package l3r_pkg;
   // regulator condition as tracked by this block
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_ON = 2'b01,
      ST_HIB = 2'b10
   } l3r_state_type;

   // sequencer indications, all synchronous to pclk
   typedef struct packed {
      logic startup_phase;
      logic shutdown_phase;
      logic [3:0] slot;
      logic enter_active;
      logic enter_off;
   } l3r_seq_type;

   // low-power trigger inputs
   typedef struct packed {
      logic low_power_input_three;
      logic low_power_input_two;
      logic low_power_input_one;
   } l3r_lp_type;
endpackage : l3r_pkg

/* l3r_regs.sv */
// control, sequencing and low-power registers of the third ldo regulator
// assumes an APB master on pclk, a sequencer and fault detector outside
// Behaviour
// - bit 14 of control selects regulation when clear and a current-limited switch when set, the voltage code then unused.
// - bit 10 of control makes a disabled output discharge when 0 and float when 1.
// - when all four regulators are disabled every output is discharged regardless of the float bit.
// - the 5-bit voltage code maps 10000..11111 to 1.8V..3.3V in 100mV steps and 00000..01111 to 0.9V..1.65V in 50mV steps.
// - a fault always raises an interrupt and then, by bits 15:14, is ignored, shuts this regulator or shuts the system (10 and 11).
// - start-up slot 0000 never starts, 0001..1110 start in that slot, 1111 starts on entering active.
// - shutdown slot 0001..1110 stops in that slot, 0000 and 1111 stop on entering off.
// - hibernate behaviour 00 switches to the image voltage and 01 disables the output, 10 and 11 reserved.
// - hibernate source 00 is the hibernate register bit, 01..11 are low-power inputs one to three.
// - the 5-bit image voltage uses the same encoding and is applied while hibernating.
// - the power state machine reset returns the fields to their mask-option defaults.
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
`include "l3r_cfg.svh"
module l3r_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sm_reset,
   input wire l3r_pkg::l3r_seq_type seq,
   input wire l3r_pkg::l3r_lp_type lp_in,
   input wire logic other_ldos_disabled,
   input wire logic regulator_fault,
   output logic ldo_enable,
   output logic switch_mode_select,
   output logic output_discharge,
   output logic [4:0] applied_code,
   output logic [11:0] target_mv,
   output logic regulator_shutdown,
   output logic system_shutdown,
   output logic irq
);
   logic [15:0] ctrl_r;
   logic [15:0] seq_r;
   logic [15:0] lp_r;
   logic [`L3R_IRQ_BITS-1:0] sts_r;
   logic [`L3R_IRQ_BITS-1:0] mask_r;
   logic hib_bit_r;
   l3r_pkg::l3r_state_type state_r;
   l3r_pkg::l3r_state_type state_nxt;
   logic fault_prev_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic ldo_enable_r;
   logic switch_r;
   logic discharge_r;
   logic [4:0] code_r;
   logic [11:0] mv_r;
   logic reg_sd_r;
   logic sys_sd_r;
   logic irq_r;
   logic [9:0] idx;
   logic setup;
   logic wr;
   logic mapped;
   logic [31:0] rd_mux;
   logic [1:0] fault_act;
   logic [3:0] start_code;
   logic [3:0] stop_code;
   logic [1:0] hib_beh;
   logic [1:0] hib_src;
   logic hib_req;
   logic start_hit;
   logic stop_hit;
   logic fault_rise;
   logic out_on;
   logic [4:0] code_sel;
   logic [`L3R_IRQ_BITS-1:0] events;

   // bus decode; one wait-free access phase follows each setup cycle
   assign idx = paddr[11:2];
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite & pready_r & ~pslverr_r;

   // field views
   assign fault_act = seq_r[`L3R_FAULT_ACT_HI:`L3R_FAULT_ACT_LO];
   assign start_code = seq_r[`L3R_START_HI:`L3R_START_LO];
   assign stop_code = seq_r[`L3R_STOP_HI:`L3R_STOP_LO];
   assign hib_beh = lp_r[`L3R_HIB_BEH_HI:`L3R_HIB_BEH_LO];
   assign hib_src = lp_r[`L3R_HIB_SRC_HI:`L3R_HIB_SRC_LO];

   // read mux and address check
   always_comb begin
      mapped = (paddr[1:0] == 2'h0);
      rd_mux = 32'h0000_0000;
      case (idx)
         `L3R_IDX_CTRL: rd_mux = {16'h0000, ctrl_r};
         `L3R_IDX_SEQ: rd_mux = {16'h0000, seq_r};
         `L3R_IDX_LP: rd_mux = {16'h0000, lp_r};
         `L3R_IDX_STS: rd_mux = {22'h0, state_r, 6'h0, sts_r};
         `L3R_IDX_MASK: rd_mux = {30'h0, mask_r};
         `L3R_IDX_HIB: rd_mux = {31'h0, hib_bit_r};
         default: mapped = 1'b0;
      endcase
   end

   // answer registered in the setup cycle so all bus outputs are flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup & ~mapped;
         if (setup && !pwrite && mapped) begin
            prdata_r <= rd_mux;
         end else if (setup) begin
            prdata_r <= 32'h0000_0000;
         end
      end
   end

   // configuration fields; the state machine reset reloads the defaults
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `L3R_DEF_CTRL;
         seq_r <= `L3R_DEF_SEQ;
         lp_r <= `L3R_DEF_LP;
      end else if (sm_reset) begin
         ctrl_r <= `L3R_DEF_CTRL;
         seq_r <= `L3R_DEF_SEQ;
         lp_r <= `L3R_DEF_LP;
      end else if (wr) begin
         if (idx == `L3R_IDX_CTRL) begin
            ctrl_r <= pwdata[15:0] & `L3R_WMASK_CTRL;
         end
         if (idx == `L3R_IDX_SEQ) begin
            seq_r <= pwdata[15:0] & `L3R_WMASK_SEQ;
         end
         if (idx == `L3R_IDX_LP) begin
            lp_r <= pwdata[15:0] & `L3R_WMASK_LP;
         end
      end
   end

   // mask and hibernate request bit are plain software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= {`L3R_IRQ_BITS{1'b0}};
         hib_bit_r <= 1'b0;
      end else if (wr) begin
         if (idx == `L3R_IDX_MASK) begin
            mask_r <= pwdata[`L3R_IRQ_BITS-1:0];
         end
         if (idx == `L3R_IDX_HIB) begin
            hib_bit_r <= pwdata[0];
         end
      end
   end

   // hibernate source select
   always_comb begin
      case (hib_src)
         2'h0: hib_req = hib_bit_r;
         2'h1: hib_req = lp_in.low_power_input_one;
         2'h2: hib_req = lp_in.low_power_input_two;
         2'h3: hib_req = lp_in.low_power_input_three;
         default: hib_req = 1'b0;
      endcase
   end

   // sequencer slot matching; slot 0000 never starts the regulator
   always_comb begin
      start_hit = 1'b0;
      stop_hit = 1'b0;
      if (start_code == `L3R_SLOT_EDGE) begin
         start_hit = seq.enter_active;
      end else if (start_code != `L3R_SLOT_NONE) begin
         start_hit = seq.startup_phase && (seq.slot == start_code);
      end
      if (stop_code == `L3R_SLOT_EDGE || stop_code == `L3R_SLOT_NONE) begin
         stop_hit = seq.enter_off;
      end else begin
         stop_hit = seq.shutdown_phase && (seq.slot == stop_code);
      end
   end

   // fault is a level; only its rising edge counts as a new event
   assign fault_rise = regulator_fault & ~fault_prev_r;

   // regulator condition; a fault shutdown outranks sequencing
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         l3r_pkg::ST_OFF: begin
            if (start_hit) begin
               state_nxt = l3r_pkg::ST_ON;
            end
         end
         l3r_pkg::ST_ON: begin
            if (stop_hit) begin
               state_nxt = l3r_pkg::ST_OFF;
            end else if (hib_req) begin
               state_nxt = l3r_pkg::ST_HIB;
            end
         end
         l3r_pkg::ST_HIB: begin
            if (stop_hit) begin
               state_nxt = l3r_pkg::ST_OFF;
            end else if (!hib_req) begin
               state_nxt = l3r_pkg::ST_ON;
            end
         end
         default: state_nxt = l3r_pkg::ST_OFF;
      endcase
      if (fault_rise && fault_act != 2'h0) begin
         state_nxt = l3r_pkg::ST_OFF;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= l3r_pkg::ST_OFF;
         fault_prev_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         fault_prev_r <= regulator_fault;
      end
   end

   // fault actions; reserved 11 is taken as a system shutdown
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reg_sd_r <= 1'b0;
         sys_sd_r <= 1'b0;
      end else begin
         reg_sd_r <= fault_rise && (fault_act == 2'h1);
         sys_sd_r <= fault_rise && fault_act[1];
      end
   end

   // sticky events; a new event beats a write-one clear in the same cycle
   assign events[`L3R_IRQ_FAULT] = fault_rise;
   assign events[`L3R_IRQ_HIB] = (state_nxt == l3r_pkg::ST_HIB) &&
                                 (state_r != l3r_pkg::ST_HIB);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_r <= {`L3R_IRQ_BITS{1'b0}};
         irq_r <= 1'b0;
      end else begin
         if (wr && idx == `L3R_IDX_STS) begin
            sts_r <= (sts_r & ~pwdata[`L3R_IRQ_BITS-1:0]) | events;
         end else begin
            sts_r <= sts_r | events;
         end
         irq_r <= |(sts_r & mask_r);
      end
   end

   // output on when active, and when hibernating unless with the disable behaviour;
   // reserved behaviours keep the image voltage, the safer choice
   assign out_on = (state_r == l3r_pkg::ST_ON) ||
                   (state_r == l3r_pkg::ST_HIB && hib_beh != 2'h1);
   assign code_sel = (state_r == l3r_pkg::ST_HIB) ?
                     lp_r[`L3R_CODE_HI:0] :
                     ctrl_r[`L3R_CODE_HI:0];

   // analogue controls, all registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ldo_enable_r <= 1'b0;
         switch_r <= 1'b0;
         discharge_r <= 1'b0;
         code_r <= 5'h00;
         mv_r <= 12'h000;
      end else begin
         ldo_enable_r <= out_on;
         switch_r <= ctrl_r[`L3R_SWITCH_BIT];
         // discharge when off unless floating, but always when all are off
         discharge_r <= ~out_on & (~ctrl_r[`L3R_FLOAT_BIT] |
                                   other_ldos_disabled);
         code_r <= code_sel;
         if (ctrl_r[`L3R_SWITCH_BIT]) begin
            mv_r <= 12'h000;
         end else if (code_sel[4]) begin
            mv_r <= `L3R_HIGH_BASE_MV +
                    12'(code_sel[3:0]) * `L3R_HIGH_STEP_MV;
         end else begin
            mv_r <= `L3R_LOW_BASE_MV +
                    12'(code_sel[3:0]) * `L3R_LOW_STEP_MV;
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign ldo_enable = ldo_enable_r;
   assign switch_mode_select = switch_r;
   assign output_discharge = discharge_r;
   assign applied_code = code_r;
   assign target_mv = mv_r;
   assign regulator_shutdown = reg_sd_r;
   assign system_shutdown = sys_sd_r;
   assign irq = irq_r;
endmodule : l3r_regs

/* l3r_regs_properties.sv */
// concurrent checks on the ports of the third ldo register block
// assumes binding onto l3r_regs, one pclk domain, presetn active low
`timescale 1ns/10ps
module l3r_regs_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   input wire logic regulator_fault,
   input wire logic other_ldos_disabled,
   input wire logic ldo_enable,
   input wire logic switch_mode_select,
   input wire logic output_discharge,
   input wire logic [4:0] applied_code,
   input wire logic [11:0] target_mv,
   input wire logic regulator_shutdown,
   input wire logic system_shutdown,
   input wire logic irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // millivolts for a code, worked out independently of the design
   function automatic logic [11:0] mv(input logic [4:0] c);
      return c[4] ? 12'h708 + 12'h064 * c[3:0] : 12'h384 + 12'h032 * c;
   endfunction : mv

   // zero wait states, ready lasts one cycle only
   a_ready_after_setup: assert property (
      psel && !penable |=> pready ##1 !pready)
      else $error("pready not one cycle after setup");
   // refused transfers carry no data
   a_error_no_data: assert property (
      pslverr |-> pready && prdata == 32'h0)
      else $error("pslverr without pready or with data");
   // switch mode drops the voltage target
   a_switch_no_volts: assert property (
      switch_mode_select |-> target_mv == 12'h000)
      else $error("target_mv not zero in switch mode");
   // an enabled output is never discharged
   a_on_no_discharge: assert property (
      ldo_enable |-> !output_discharge)
      else $error("discharge while enabled");
   // every regulator off forces discharge, float bit or not
   a_all_off_drain: assert property (
      (other_ldos_disabled && !ldo_enable)[*3] |-> output_discharge)
      else $error("no discharge with all regulators off");
   // the target tracks the code in use; skip the edge right after reset
   a_code_to_volts: assert property (
      $past(presetn) && !switch_mode_select |->
      target_mv == mv(applied_code))
      else $error("target_mv does not match applied_code");
   // a shutdown pulse follows one edge after the fault rises
   a_shutdown_cause: assert property (
      regulator_shutdown || system_shutdown |->
      $past(regulator_fault) && !$past(regulator_fault, 2))
      else $error("shutdown pulse without a fresh fault");
   // pulses are single and exclusive, the output drops afterwards
   a_pulse_single: assert property (
      regulator_shutdown || system_shutdown |->
      !(regulator_shutdown && system_shutdown) ##1
      !regulator_shutdown && !system_shutdown && !ldo_enable)
      else $error("shutdown pulse malformed or output kept on");

   c_reg_down: cover property (regulator_shutdown);
   c_sys_down: cover property (system_shutdown);
   c_refused: cover property (pslverr);
   c_irq: cover property (irq);
endmodule : l3r_regs_properties

/* tb_top.sv */
// directed testbench for the third ldo register block
// assumes l3r_regs with its header and package compiled first
`timescale 1ns/10ps
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic sm_reset, other_ldos_disabled, regulator_fault, ldo_enable, irq;
   logic switch_mode_select, output_discharge, rs, ss;
   logic regulator_shutdown, system_shutdown;
   logic [11:0] paddr, target_mv;
   logic [31:0] pwdata, prdata, q;
   logic [4:0] applied_code;
   l3r_pkg::l3r_seq_type seq;
   l3r_pkg::l3r_lp_type lp_in;
   int miscompares = 0, checks = 0, cycles = 0;
   localparam logic [11:0] CTRL = 12'h338, SEQ = 12'h33C, LP = 12'h340;
   localparam logic [11:0] STS = 12'h360, MSK = 12'h364, HIB = 12'h368;

   l3r_regs i_l3r_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sm_reset(sm_reset), .seq(seq), .lp_in(lp_in),
      .other_ldos_disabled(other_ldos_disabled),
      .regulator_fault(regulator_fault), .ldo_enable(ldo_enable),
      .switch_mode_select(switch_mode_select),
      .output_discharge(output_discharge), .applied_code(applied_code),
      .target_mv(target_mv), .regulator_shutdown(regulator_shutdown),
      .system_shutdown(system_shutdown), .irq(irq));

   // 40 ns clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         results();
      end
   end

   task results;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results

   task check(input string n, input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x) begin
         miscompares++;
         $display("unexpected %s expected %0h seen %0h", n, x, g);
      end
   endtask : check

   task tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : tick

   // one apb transfer; waits for pready, only the hang guard ends a wait
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      check("prdata", q, x);
   endtask : rd

   // one cycle of sequencer indication, then let outputs settle
   task pulse(input logic [7:0] s);
      @(posedge pclk) seq <= s;
      @(posedge pclk) seq <= '0;
      tick(3);
   endtask : pulse

   task t_defaults;
      rd(CTRL, 32'h001B);
      rd(SEQ, 32'h0400);
      rd(LP, 32'h001C);
      rd(12'h100, 32'h0);
      check("pslverr", e, 32'h1);
      // misaligned address is refused like an unmapped one
      rd(12'h33A, 32'h0);
      check("pslverr", e, 32'h1);
      wr(CTRL, 32'hFFFFFFFF);
      rd(CTRL, 32'h441F);
      @(posedge pclk) sm_reset <= 1'b1;
      @(posedge pclk) sm_reset <= 1'b0;
      rd(CTRL, 32'h001B);
   endtask : t_defaults

   task t_volts;
      for (int i = 0; i < 32; i++) begin
         wr(CTRL, i);
         tick(3);
         check("mv", target_mv,
               i < 16 ? 900 + 50 * i : 200 + 100 * i);
      end
      wr(CTRL, 32'h4010);
      tick(3);
      check("switch", {switch_mode_select, target_mv}, 32'h1000);
      wr(CTRL, 32'h001B);
   endtask : t_volts

   task t_seq;
      check("drain", output_discharge, 32'h1);
      pulse(8'hC8);
      check("on", ldo_enable, 32'h0);
      pulse(8'h84);
      check("on", {ldo_enable, output_discharge}, 32'h2);
      wr(SEQ, 32'h3CC0);
      pulse(8'h48);
      check("on", ldo_enable, 32'h1);
      pulse(8'h4C);
      check("on", ldo_enable, 32'h0);
      wr(CTRL, 32'h041B);
      tick(3);
      check("drain", output_discharge, 32'h0);
      @(posedge pclk) other_ldos_disabled <= 1'b1;
      tick(4);
      check("drain", output_discharge, 32'h1);
      @(posedge pclk) other_ldos_disabled <= 1'b0;
      pulse(8'h02);
      check("on", ldo_enable, 32'h1);
      wr(SEQ, 32'h03C0);
      pulse(8'h01);
      check("on", ldo_enable, 32'h0);
      pulse(8'h02);
      check("on", ldo_enable, 32'h0);
      wr(SEQ, 32'h3C00);
      pulse(8'h02);
   endtask : t_seq

   task t_hib;
      for (int s = 0; s < 4; s++) begin
         // sources two and three also try the reserved behaviours
         wr(LP, (s << 8) | (s > 1 ? s << 12 : 0) | 32'h05);
         if (s == 0) wr(HIB, 32'h1);
         else @(posedge pclk) lp_in <= 3'h1 << (s - 1);
         tick(3);
         check("image", {ldo_enable, applied_code}, 32'h25);
         if (s == 0) wr(HIB, 32'h0);
         else @(posedge pclk) lp_in <= '0;
         tick(3);
         check("image", applied_code, 32'h1B);
      end
      wr(LP, 32'h1000);
      wr(HIB, 32'h1);
      tick(3);
      check("on", ldo_enable, 32'h0);
      wr(HIB, 32'h0);
      tick(3);
      rd(STS, 32'h0102);
      wr(STS, 32'h2);
   endtask : t_hib

   task t_fault;
      wr(MSK, 32'h1);
      for (int a = 0; a < 5; a++) begin
         if (a == 4) wr(MSK, 32'h0);
         wr(SEQ, ((a & 3) << 14) | 32'h3C00);
         pulse(8'h02);
         rs = 1'b0;
         ss = 1'b0;
         @(posedge pclk) regulator_fault <= 1'b1;
         repeat (3) begin
            tick(1);
            rs |= regulator_shutdown;
            ss |= system_shutdown;
         end
         check("down", {rs, ss, ldo_enable},
               a == 1 ? 4 : a == 0 || a == 4 ? 1 : 2);
         check("irq", irq, a != 4);
         @(posedge pclk) regulator_fault <= 1'b0;
         rd(STS, a > 0 && a < 4 ? 32'h1 : 32'h0101);
         wr(STS, 32'h1);
         tick(2);
         check("irq", irq, 32'h0);
      end
   endtask : t_fault

   // reset for four cycles, then the scenarios in turn
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      sm_reset = 1'b0;
      seq = '0;
      lp_in = '0;
      other_ldos_disabled = 1'b0;
      regulator_fault = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_defaults();
      t_volts();
      t_seq();
      t_hib();
      t_fault();
      results();
   end
endmodule : tb_top

bind l3r_regs l3r_regs_properties i_l3r_regs_properties (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pready(pready),
   .pslverr(pslverr),
   .prdata(prdata),
   .regulator_fault(regulator_fault),
   .other_ldos_disabled(other_ldos_disabled),
   .ldo_enable(ldo_enable),
   .switch_mode_select(switch_mode_select),
   .output_discharge(output_discharge),
   .applied_code(applied_code),
   .target_mv(target_mv),
   .regulator_shutdown(regulator_shutdown),
   .system_shutdown(system_shutdown),
   .irq(irq)
);
